// File: jump_unit_pkg.sv
package jump_unit_pkg;

	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int PC_W     = 20;
	localparam int OFFSET_W = 10;
	localparam int SR_W     = 16;

	// ==========================================================================
	// Status register field positions
	// ==========================================================================
	localparam int SR_C_POS      = 0;
	localparam int SR_Z_POS      = 1;
	localparam int SR_N_POS      = 2;
	localparam int SR_GIE_POS    = 3;
	localparam int SR_PROCESSOR_HALT_BIT_POS = 4;
	localparam int SR_OSCILLATOR_OFF_BIT_POS = 5;
	localparam int SR_V_POS      = 8;

	// ==========================================================================
	// Reset values and step sizes
	// ==========================================================================
	localparam logic [SR_W-1:0] SR_RESET       = 16'h0000;
	localparam logic [PC_W-1:0] PC_RESET       = 20'h00000;
	localparam logic [PC_W-1:0] JUMP_INSTR_LEN = 20'h00002;

	// Word distance reachable from the jump instruction
	localparam int REACH_BACK_WORDS = 511;
	localparam int REACH_FWD_WORDS  = 512;

	// ==========================================================================
	// Jump kinds
	// ==========================================================================
	typedef enum logic [2:0] {
		jump_on_zero              = 3'h0,
		jump_on_no_carry          = 3'h1,
		jump_on_carry             = 3'h2,
		jump_on_negative          = 3'h3,
		jump_signed_greater_equal = 3'h4,
		jump_signed_less          = 3'h5,
		jump_unconditional        = 3'h6,
		jump_kind_spare           = 3'h7
	} jump_kind_t;

	// Alternative names decode to the very same operation
	localparam jump_kind_t jump_unsigned_higher_same = jump_on_carry;
	localparam jump_kind_t jump_unsigned_lower       = jump_on_no_carry;
	localparam jump_kind_t jump_if_equal             = jump_on_zero;
	localparam jump_kind_t jump_if_positive          = jump_signed_greater_equal;

	// ==========================================================================
	// Address arithmetic
	// ==========================================================================
	// Word offset doubled, sign-extended, added past the one-word instruction
	function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
		input logic [OFFSET_W-1:0] off);
		logic [PC_W-1:0] ext;
		ext = {{(PC_W-OFFSET_W-1){off[OFFSET_W-1]}}, off, 1'b0};
		return pc + JUMP_INSTR_LEN + ext;
	endfunction

	function automatic logic [PC_W-1:0] seq_next(input logic [PC_W-1:0] pc);
		return pc + JUMP_INSTR_LEN;
	endfunction

endpackage

// File: jump_cond_if.sv
`timescale 1ns/1ps
interface jump_cond_if;
	import jump_unit_pkg::*;
	jump_kind_t kind;
	logic       flag_n;
	logic       flag_z;
	logic       flag_c;
	logic       flag_v;
	logic       take;

	modport eval (input kind, input flag_n, input flag_z, input flag_c, input flag_v, output take);
	modport user (output kind, output flag_n, output flag_z, output flag_c, output flag_v, input take);
endinterface

// File: jump_cond_eval.sv
`timescale 1ns/1ps
module jump_cond_eval
	import jump_unit_pkg::*;
(
	jump_cond_if.eval cond    // Kind and flags in, decision out
);

	// ==========================================================================
	// Per-kind decisions
	// ==========================================================================
	wire signed_ge  = ~(cond.flag_n ^ cond.flag_v);
	wire signed_lt  = cond.flag_n ^ cond.flag_v;
	wire on_zero    = cond.flag_z;
	wire on_carry   = cond.flag_c;
	wire on_no_c    = ~cond.flag_c;
	wire on_neg     = cond.flag_n;

	// Aliased kinds share codes, so one case arm serves both names
	assign cond.take = (cond.kind == jump_on_zero)              ? on_zero   :
	                   (cond.kind == jump_on_carry)             ? on_carry  :
	                   (cond.kind == jump_on_no_carry)          ? on_no_c   :
	                   (cond.kind == jump_on_negative)          ? on_neg    :
	                   (cond.kind == jump_signed_greater_equal) ? signed_ge :
	                   (cond.kind == jump_signed_less)          ? signed_lt :
	                   (cond.kind == jump_unconditional)        ? 1'b1      :
	                   1'b0;

endmodule

// File: conditional_jump_unit.sv
`timescale 1ns/1ps
// What this block does
// - Carry set: load target, else continue
// - Zero set: branch; zero clear: fall through
// - Target is PC plus 2 plus doubled, extended offset
// - Reach 511 words back, 512 forward
// - Greater-equal branches when N equals V
// - Less branches when N differs from V
// - Unconditional always loads the relative target
// - Negative set: branch; clear: next instruction
// - Carry clear: branch; carry set: continue
// - Alias names decode to identical operations
// - Jumps never change N, Z, C, V
// - Jumps never change halt, oscillator, interrupt-enable
// - Logic, test, rotate, extend ops clear V
module conditional_jump_unit
	import jump_unit_pkg::*;
(
	input  wire logic                clock,           // Core clock, 100 MHz
	input  wire logic                resetn,          // Synchronous reset, active low
	input  wire logic                jump_valid,      // Jump instruction issued this cycle
	input  wire jump_kind_t          jump_kind,       // Which jump
	input  wire logic [OFFSET_W-1:0] jump_offset,     // Signed word offset from the word after the instruction
	input  wire logic [PC_W-1:0]     jump_pc,         // Address of the jump instruction
	input  wire logic                flags_we,        // Another instruction writes the status register
	input  wire logic [SR_W-1:0]     flags_wdata,     // Value written to the status register
	input  wire logic                flags_clear_v,   // Writer is a logic, test, rotate or extend op
	output logic      [PC_W-1:0]     pc_next_r,       // Program counter after the jump
	output logic                     branch_taken_r,  // The last jump was taken
	output logic                     jump_done_r,     // One-cycle pulse: pc_next_r is fresh
	output logic      [SR_W-1:0]     status_r         // Status register
);

	// ==========================================================================
	// Status register write path
	// ==========================================================================
	logic [SR_W-1:0] status_nxt;
	logic [SR_W-1:0] v_mask;

	assign v_mask = ~(16'h0001 << SR_V_POS);

	// Jumps have no write port here, so flags and mode bits survive them
	assign status_nxt = !flags_we     ? status_r :
	                    flags_clear_v ? (flags_wdata & v_mask) :
	                    flags_wdata;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			status_r <= SR_RESET;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ==========================================================================
	// Flags seen by the jump
	// ==========================================================================
	// A flag write in the same cycle is forwarded, so a compare followed at once
	// by its jump needs no stall
	logic [SR_W-1:0] flags_eff;

	assign flags_eff = status_nxt;

	// ==========================================================================
	// Condition evaluation
	// ==========================================================================
	jump_cond_if cond_bus ();

	assign cond_bus.kind   = jump_kind;
	assign cond_bus.flag_n = flags_eff[SR_N_POS];
	assign cond_bus.flag_z = flags_eff[SR_Z_POS];
	assign cond_bus.flag_c = flags_eff[SR_C_POS];
	assign cond_bus.flag_v = flags_eff[SR_V_POS];

	jump_cond_eval u_cond (
		.cond (cond_bus.eval)
	);

	// ==========================================================================
	// Next program counter
	// ==========================================================================
	logic [PC_W-1:0] target_addr;
	logic [PC_W-1:0] fall_addr;
	logic [PC_W-1:0] pc_next_nxt;
	logic            taken_nxt;

	assign target_addr = rel_target(jump_pc, jump_offset);
	assign fall_addr   = seq_next(jump_pc);
	assign taken_nxt   = jump_valid ? cond_bus.take : branch_taken_r;
	assign pc_next_nxt = !jump_valid   ? pc_next_r   :
	                     cond_bus.take ? target_addr :
	                     fall_addr;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			pc_next_r      <= PC_RESET;
			branch_taken_r <= 1'b0;
			jump_done_r    <= 1'b0;
		end else begin
			pc_next_r      <= pc_next_nxt;
			branch_taken_r <= taken_nxt;
			jump_done_r    <= jump_valid;
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	logic signed [PC_W-1:0] jump_dist;
	logic        [PC_W-1:0] past_pc;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			past_pc <= PC_RESET;
		end else if (jump_valid) begin
			past_pc <= jump_pc;
		end
	end

	// Byte distance from the jump instruction to where execution goes
	assign jump_dist = signed'(pc_next_r - past_pc);

	sequence s_req(jump_kind_t k);
		jump_valid && (jump_kind == k);
	endsequence

	sequence s_result(logic exp_take, logic [PC_W-1:0] tgt, logic [PC_W-1:0] nxt);
		jump_done_r && (branch_taken_r == exp_take) && (pc_next_r == (exp_take ? tgt : nxt));
	endsequence

	property p_carry;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_on_carry) |=>
			s_result($past(flags_eff[SR_C_POS]), $past(target_addr), $past(fall_addr));
	endproperty
	a_carry: assert property (p_carry) else $error("carry jump decision wrong");

	property p_zero;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_if_equal) |=> branch_taken_r == $past(flags_eff[SR_Z_POS]);
	endproperty
	a_zero: assert property (p_zero) else $error("zero jump decision wrong");

	property p_target;
		@(posedge clock) disable iff (!resetn)
		jump_valid && cond_bus.take |=>
			pc_next_r == $past(jump_pc) + 20'h00002 + {{9{$past(jump_offset[9])}}, $past(jump_offset), 1'b0};
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");

	property p_reach;
		@(posedge clock) disable iff (!resetn)
		jump_valid && cond_bus.take |=>
			(jump_dist >= -2 * REACH_BACK_WORDS) && (jump_dist <= 2 * REACH_FWD_WORDS) && !jump_dist[0];
	endproperty
	a_reach: assert property (p_reach) else $error("jump outside reach");

	property p_ge;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_signed_greater_equal) |=>
			branch_taken_r == !($past(flags_eff[SR_N_POS]) ^ $past(flags_eff[SR_V_POS]));
	endproperty
	a_ge: assert property (p_ge) else $error("greater-equal decision wrong");

	property p_less;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_signed_less) |=>
			branch_taken_r == ($past(flags_eff[SR_N_POS]) ^ $past(flags_eff[SR_V_POS]));
	endproperty
	a_less: assert property (p_less) else $error("less decision wrong");

	property p_always;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_unconditional) |=> s_result(1'b1, $past(target_addr), $past(fall_addr));
	endproperty
	a_always: assert property (p_always) else $error("unconditional jump not taken");

	property p_negative;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_on_negative) |=> branch_taken_r == $past(flags_eff[SR_N_POS]);
	endproperty
	a_negative: assert property (p_negative) else $error("negative jump decision wrong");

	property p_no_carry;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_unsigned_lower) |=> branch_taken_r == !$past(flags_eff[SR_C_POS]);
	endproperty
	a_no_carry: assert property (p_no_carry) else $error("no-carry jump decision wrong");

	property p_alias_hs;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_unsigned_higher_same) |=> branch_taken_r == $past(flags_eff[SR_C_POS]);
	endproperty
	a_alias_hs: assert property (p_alias_hs) else $error("higher-same differs from carry");

	property p_flags_kept;
		@(posedge clock) disable iff (!resetn)
		jump_valid && !flags_we |=>
			status_r[SR_N_POS] == $past(status_r[SR_N_POS]) && status_r[SR_Z_POS] == $past(status_r[SR_Z_POS]) &&
			status_r[SR_C_POS] == $past(status_r[SR_C_POS]) && status_r[SR_V_POS] == $past(status_r[SR_V_POS]);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("jump changed a status flag");

	property p_mode_kept;
		@(posedge clock) disable iff (!resetn)
		jump_valid && !flags_we |=> $stable(status_r[SR_GIE_POS]) && $stable(status_r[SR_PROCESSOR_HALT_BIT_POS]) &&
			$stable(status_r[SR_OSCILLATOR_OFF_BIT_POS]);
	endproperty
	a_mode_kept: assert property (p_mode_kept) else $error("jump changed a mode bit");

	property p_clear_v;
		@(posedge clock) disable iff (!resetn)
		flags_we && flags_clear_v |=> !status_r[SR_V_POS] ##0
			(status_r[SR_N_POS] == $past(flags_wdata[SR_N_POS]));
	endproperty
	a_clear_v: assert property (p_clear_v) else $error("overflow not cleared");

	property p_fall;
		@(posedge clock) disable iff (!resetn)
		jump_valid && !cond_bus.take |=> s_result(1'b0, $past(target_addr), $past(jump_pc) + 20'h00002);
	endproperty
	a_fall: assert property (p_fall) else $error("fall-through address wrong");

	property p_done_pulse;
		@(posedge clock) disable iff (!resetn)
		!jump_valid |=> !jump_done_r && $stable(pc_next_r);
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("result changed without a jump");

	// ==========================================================================
	// Status writes, forwarding and the remaining kinds
	// ==========================================================================
	sequence s_flag_write(logic clr);
		flags_we && (flags_clear_v == clr);
	endsequence

	property p_spare;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_kind_spare) |=>
			s_result(1'b0, $past(target_addr), $past(fall_addr));
	endproperty
	a_spare: assert property (p_spare) else $error("spare kind did not fall through");

	property p_done_rise;
		@(posedge clock) disable iff (!resetn)
		jump_valid |=>
			jump_done_r;
	endproperty
	a_done_rise: assert property (p_done_rise) else $error("no done pulse after a jump");

	property p_taken_hold;
		@(posedge clock) disable iff (!resetn)
		!jump_valid |=>
			$stable(branch_taken_r);
	endproperty
	a_taken_hold: assert property (p_taken_hold) else $error("taken flag changed without a jump");

	property p_status_write;
		@(posedge clock) disable iff (!resetn)
		s_flag_write(1'b0) |=>
			status_r == $past(flags_wdata);
	endproperty
	a_status_write: assert property (p_status_write) else $error("plain status write altered");

	property p_status_hold;
		@(posedge clock) disable iff (!resetn)
		!flags_we |=>
			$stable(status_r);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status changed without a write");

	property p_clear_rest;
		@(posedge clock) disable iff (!resetn)
		s_flag_write(1'b1) |=>
			(status_r | (16'h0001 << SR_V_POS)) == ($past(flags_wdata) | (16'h0001 << SR_V_POS));
	endproperty
	a_clear_rest: assert property (p_clear_rest) else $error("overflow clear touched other bits");

	property p_fwd_carry;
		@(posedge clock) disable iff (!resetn)
		jump_valid && flags_we && (jump_kind == jump_on_carry) |=>
			branch_taken_r == $past(flags_wdata[SR_C_POS]);
	endproperty
	a_fwd_carry: assert property (p_fwd_carry) else $error("same-cycle carry not forwarded");

	property p_zero_addr;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_on_zero) |=>
			s_result($past(flags_eff[SR_Z_POS]), $past(target_addr), $past(fall_addr));
	endproperty
	a_zero_addr: assert property (p_zero_addr) else $error("zero jump address wrong");

	property p_neg_addr;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_on_negative) |=>
			s_result($past(flags_eff[SR_N_POS]), $past(target_addr), $past(fall_addr));
	endproperty
	a_neg_addr: assert property (p_neg_addr) else $error("negative jump address wrong");

	property p_less_addr;
		@(posedge clock) disable iff (!resetn)
		s_req(jump_signed_less) |=>
			s_result($past(flags_eff[SR_N_POS] ^ flags_eff[SR_V_POS]), $past(target_addr), $past(fall_addr));
	endproperty
	a_less_addr: assert property (p_less_addr) else $error("less jump address wrong");

	// With V already clear the greater-equal kind acts as jump-if-positive
	property p_positive;
		@(posedge clock) disable iff (!resetn)
		jump_valid && (jump_kind == jump_if_positive) && !flags_we && !status_r[SR_V_POS] |=>
			branch_taken_r == !$past(status_r[SR_N_POS]);
	endproperty
	a_positive: assert property (p_positive) else $error("positive test wrong with V clear");

endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb
	import jump_unit_pkg::*;
;
	// ==========================================================================
	// Clock, reset and stimulus
	// ==========================================================================
	logic                clock;
	logic                resetn;
	logic                jump_valid;
	jump_kind_t          jump_kind;
	logic [OFFSET_W-1:0] jump_offset;
	logic [PC_W-1:0]     jump_pc;
	logic                flags_we;
	logic [SR_W-1:0]     flags_wdata;
	logic                flags_clear_v;
	logic [PC_W-1:0]     pc_next_r;
	logic                branch_taken_r;
	logic                jump_done_r;
	logic [SR_W-1:0]     status_r;
	int                  bad_count;
	int                  checked;
	logic [SR_W-1:0]     sr;
	jump_kind_t          kk;
	logic [OFFSET_W-1:0] off;
	logic [PC_W-1:0]     pc;
	logic                t;

	conditional_jump_unit uut (
		.clock          (clock),
		.resetn         (resetn),
		.jump_valid     (jump_valid),
		.jump_kind      (jump_kind),
		.jump_offset    (jump_offset),
		.jump_pc        (jump_pc),
		.flags_we       (flags_we),
		.flags_wdata    (flags_wdata),
		.flags_clear_v  (flags_clear_v),
		.pc_next_r      (pc_next_r),
		.branch_taken_r (branch_taken_r),
		.jump_done_r    (jump_done_r),
		.status_r       (status_r)
	);

	always #5 clock = ~clock;

	// ==========================================================================
	// Reference model
	// ==========================================================================
	function automatic logic exp_take(input jump_kind_t k, input logic [SR_W-1:0] s);
		logic n, z, c, v;
		n = s[SR_N_POS];
		z = s[SR_Z_POS];
		c = s[SR_C_POS];
		v = s[SR_V_POS];
		case (k)
			jump_on_zero:              return z;
			jump_on_no_carry:          return ~c;
			jump_on_carry:             return c;
			jump_on_negative:          return n;
			jump_signed_greater_equal: return ~(n ^ v);
			jump_signed_less:          return n ^ v;
			jump_unconditional:        return 1'b1;
			default:                   return 1'b0;
		endcase
	endfunction

	// Written out independently so a shared slip cannot hide itself
	function automatic logic [PC_W-1:0] tgt(input logic [PC_W-1:0] p, input logic [OFFSET_W-1:0] o, input logic tk);
		if (tk) begin
			return p + 20'h00002 + {{9{o[9]}}, o, 1'b0};
		end
		return p + 20'h00002;
	endfunction

	// ==========================================================================
	// Access tasks
	// ==========================================================================
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic set_flags(input logic [SR_W-1:0] d, input logic clr, input logic [SR_W-1:0] exp);
		@(posedge clock);
		flags_we      <= 1'b1;
		flags_wdata   <= d;
		flags_clear_v <= clr;
		@(posedge clock);
		flags_we      <= 1'b0;
		flags_clear_v <= 1'b0;
		#1;
		chk("status_write", 32'(exp), 32'(status_r));
		chk("done_idle", 32'h0, 32'(jump_done_r));
	endtask

	task automatic do_jump(input jump_kind_t k, input logic [OFFSET_W-1:0] o, input logic [PC_W-1:0] p,
		input logic tk, input logic [PC_W-1:0] exp_pc);
		logic [SR_W-1:0] sr0;
		sr0 = status_r;
		@(posedge clock);
		jump_valid  <= 1'b1;
		jump_kind   <= k;
		jump_offset <= o;
		jump_pc     <= p;
		@(posedge clock);
		jump_valid  <= 1'b0;
		#1;
		chk("jump_done", 32'h1, 32'(jump_done_r));
		chk("taken", 32'(tk), 32'(branch_taken_r));
		chk("pc_next", 32'(exp_pc), 32'(pc_next_r));
		chk("status_kept", 32'(sr0), 32'(status_r));
	endtask

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================================
	// Tests
	// ==========================================================================
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		jump_valid = 1'b0;
		jump_kind = jump_on_zero;
		jump_offset = 10'h000;
		jump_pc = 20'h00000;
		flags_we = 1'b0;
		flags_wdata = 16'h0000;
		flags_clear_v = 1'b0;
		bad_count = 0;
		checked = 0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		#1;
		chk("reset_pc", 32'h0, 32'(pc_next_r));
		chk("reset_status", 32'h0, 32'(status_r));
		// Every kind against every N/Z/C/V mix, mode bits toggled too
		for (int f = 0; f < 16; f++) begin
			sr = (f[1] ^ f[3]) ? 16'h0038 : 16'h0000;
			sr[SR_C_POS] = f[0];
			sr[SR_Z_POS] = f[1];
			sr[SR_N_POS] = f[2];
			sr[SR_V_POS] = f[3];
			set_flags(sr, 1'b0, sr);
			for (int k = 0; k < 8; k++) begin
				kk = jump_kind_t'(k);
				off = 10'(f * 37 + k * 61);
				pc = 20'(f * 32'h0f0f2 + k * 2);
				t = exp_take(kk, sr);
				do_jump(kk, off, pc, t, tgt(pc, off, t));
			end
		end
		// Reach limits and wrap of the 20-bit space
		do_jump(jump_unconditional, 10'h200, 20'h10000, 1'b1, 20'h0fc02);
		do_jump(jump_unconditional, 10'h1ff, 20'h10000, 1'b1, 20'h10400);
		do_jump(jump_unconditional, 10'h1ff, 20'hffffe, 1'b1, 20'h003fe);
		do_jump(jump_unconditional, 10'h200, 20'h00000, 1'b1, 20'hffc02);
		// Alternative names
		set_flags(16'h0003, 1'b0, 16'h0003);
		do_jump(jump_unsigned_higher_same, 10'h004, 20'h00400, 1'b1, 20'h0040a);
		do_jump(jump_if_equal, 10'h004, 20'h00400, 1'b1, 20'h0040a);
		do_jump(jump_unsigned_lower, 10'h004, 20'h00400, 1'b0, 20'h00402);
		// V cleared by logic-type writers, kept otherwise
		set_flags(16'h0100, 1'b0, 16'h0100);
		do_jump(jump_if_positive, 10'h005, 20'h00400, 1'b0, 20'h00402);
		set_flags(16'h0100, 1'b1, 16'h0000);
		do_jump(jump_if_positive, 10'h005, 20'h00400, 1'b1, 20'h0040c);
		set_flags(16'h0104, 1'b1, 16'h0004);
		do_jump(jump_signed_less, 10'h3ff, 20'h00400, 1'b1, 20'h00400);
		// Flag write and jump in one cycle, then a second jump straight after
		@(posedge clock);
		flags_we      <= 1'b1;
		flags_wdata   <= 16'h0001;
		flags_clear_v <= 1'b0;
		jump_valid    <= 1'b1;
		jump_kind     <= jump_on_carry;
		jump_offset   <= 10'h010;
		jump_pc       <= 20'h00800;
		@(posedge clock);
		flags_we  <= 1'b0;
		jump_kind <= jump_on_no_carry;
		#1;
		chk("fwd_taken", 32'h1, 32'(branch_taken_r));
		chk("fwd_pc", 32'h00822, 32'(pc_next_r));
		@(posedge clock);
		jump_valid <= 1'b0;
		#1;
		chk("b2b_done", 32'h1, 32'(jump_done_r));
		chk("b2b_taken", 32'h0, 32'(branch_taken_r));
		chk("b2b_pc", 32'h00802, 32'(pc_next_r));
		chk("b2b_status", 32'h0001, 32'(status_r));
		print_verdict();
	end

	// Whole run is a few hundred cycles
	initial begin
		#50000;
		bad_count++;
		$display("FAIL watchdog expected finish seen timeout");
		print_verdict();
	end
endmodule
